// [core/uim_mask.sv]
// Module: UART interrupt mask register with APB slave and combined interrupt line
//
// What this block does
// - Bit 9 masks break error, reset 0; set forwards raw break error.
// - Bit 8 masks parity error, reset 0; set forwards raw parity error.
// - Bit 6 masks receive time-out, reset 0; set forwards raw time-out.
// - Mask reads return the stored mask values, not raw interrupt state.
// - Bit 4 masks receive, reset 0; set forwards raw receive condition.
// - Bit 10 masks overrun error; set forwards raw overrun condition.
// - Bit 5 masks transmit, reset 0; read returns its setting.
// - Transmit mask set forwards raw transmit condition.
// - Bits 3:0 reserved, read as zero, writes ignored.
// - Cleared mask blocks its source; raw condition itself untouched.
`timescale 1ns/10ps
module uim_mask
	import uim_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        overrun_err_raw,
	input  wire logic        break_err_raw,
	input  wire logic        parity_err_raw,
	input  wire logic        framing_err_raw,
	input  wire logic        rx_timeout_raw,
	input  wire logic        tx_irq_raw,
	input  wire logic        rx_irq_raw,
	output logic             uart_irq
);

	// ----------------------------------------------------------------
	// Source vector, ordered by bit position
	// ----------------------------------------------------------------
	logic [UIM_NSRC-1:0] raw_vec;
	logic [UIM_NSRC-1:0] mask_reg;
	logic [UIM_NSRC-1:0] masked_vec;

	assign raw_vec = {overrun_err_raw, break_err_raw, parity_err_raw, framing_err_raw,
		rx_timeout_raw, tx_irq_raw, rx_irq_raw};

	// Place a source vector into its register bits, reserved bits zero
	function automatic logic [31:0] uim_place(input logic [UIM_NSRC-1:0] v);
		logic [31:0] w;
		w = UIM_RDATA_IDLE;
		w[UIM_MSB:UIM_LSB] = v;
		w[UIM_LSB-1:0] = UIM_RSVD_LOW;
		return w;
	endfunction : uim_place

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic access;
	logic hit_mask;
	logic hit_raw;
	logic hit_mis;
	logic hit_any;

	assign access   = psel && penable;
	assign hit_mask = (paddr == UIM_MASK_OFFSET);
	assign hit_raw  = (paddr == UIM_RAW_OFFSET);
	assign hit_mis  = (paddr == UIM_MIS_OFFSET);
	assign hit_any  = hit_mask || hit_raw || hit_mis;
	// No wait states: read data is captured in the setup cycle
	assign pready   = 1'b1;
	// Status offsets swallow writes; only unmapped offsets report an error
	assign pslverr  = access && !hit_any;

	// ----------------------------------------------------------------
	// Mask register
	// ----------------------------------------------------------------
	// Only the source bits are stored; reserved bits are rebuilt on read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= UIM_MASK_RESET;
		end else if (access && pwrite && hit_mask) begin
			mask_reg <= pwdata[UIM_MSB:UIM_LSB];
		end
	end

	// ----------------------------------------------------------------
	// Gating and combined line
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < UIM_NSRC; i++) begin : g_gate
			assign masked_vec[i] = raw_vec[i] & mask_reg[i];
		end
	endgenerate

	assign uart_irq = |masked_vec;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Raw and masked views are read-only copies of the gating input and output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= UIM_RDATA_IDLE;
		end else if (psel && !penable && !pwrite) begin
			if (hit_mask) begin
				prdata <= uim_place(mask_reg);
			end else if (hit_raw) begin
				prdata <= uim_place(raw_vec);
			end else if (hit_mis) begin
				prdata <= uim_place(masked_vec);
			end else begin
				prdata <= UIM_RDATA_IDLE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_mask_write(int b);
		access && pwrite && hit_mask && pwdata[b];
	endsequence

	sequence s_read_setup(logic hit);
		psel && !penable && !pwrite && hit;
	endsequence

	sequence s_write_access(logic hit);
		access && pwrite && hit;
	endsequence

	a_mask_reset: assert property (@(posedge pclk)
		!presetn |=> (mask_reg == UIM_MASK_RESET) && !uart_irq)
		else $error("mask not cleared by reset");
	a_break_forward: assert property (@(posedge pclk) disable iff (!presetn)
		(mask_reg[UIM_BE_BIT-UIM_LSB] && break_err_raw) |-> uart_irq)
		else $error("break error not forwarded");
	a_parity_forward: assert property (@(posedge pclk) disable iff (!presetn)
		(mask_reg[UIM_PE_BIT-UIM_LSB] && parity_err_raw) |-> uart_irq)
		else $error("parity error not forwarded");
	a_timeout_forward: assert property (@(posedge pclk) disable iff (!presetn)
		s_mask_write(UIM_RT_BIT) ##1 (rx_timeout_raw && mask_reg[UIM_RT_BIT-UIM_LSB])
		|-> uart_irq)
		else $error("time-out not forwarded after enable");
	a_read_mask: assert property (@(posedge pclk) disable iff (!presetn)
		s_read_setup(hit_mask) |=>
		prdata[UIM_MSB:UIM_LSB] == $past(mask_reg))
		else $error("read does not return mask");
	a_rx_forward: assert property (@(posedge pclk) disable iff (!presetn)
		(mask_reg[UIM_RX_BIT-UIM_LSB] && rx_irq_raw) |-> uart_irq)
		else $error("receive not forwarded");
	a_overrun_forward: assert property (@(posedge pclk) disable iff (!presetn)
		(mask_reg[UIM_OE_BIT-UIM_LSB] && overrun_err_raw) |-> uart_irq)
		else $error("overrun not forwarded");
	a_tx_write: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && hit_mask) |=>
		mask_reg[UIM_TX_BIT-UIM_LSB] == $past(pwdata[UIM_TX_BIT]))
		else $error("transmit mask not stored");
	a_tx_forward: assert property (@(posedge pclk) disable iff (!presetn)
		(mask_reg[UIM_TX_BIT-UIM_LSB] && tx_irq_raw) |-> uart_irq)
		else $error("transmit not forwarded");
	a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
		prdata[UIM_LSB-1:0] == UIM_RSVD_LOW && prdata[31:UIM_MSB+1] == '0)
		else $error("reserved bits not zero");
	a_block_masked: assert property (@(posedge pclk) disable iff (!presetn)
		((raw_vec & mask_reg) == '0) |-> !uart_irq)
		else $error("masked source reached line");
	a_frame_forward: assert property (@(posedge pclk) disable iff (!presetn)
		(mask_reg[UIM_FE_BIT-UIM_LSB] && framing_err_raw) |-> uart_irq)
		else $error("framing error not forwarded");
	a_irq_or: assert property (@(posedge pclk) disable iff (!presetn)
		uart_irq |-> ((raw_vec & mask_reg) != '0))
		else $error("line high without enabled source");

	// ----------------------------------------------------------------
	// Register checks
	// ----------------------------------------------------------------
	a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_access(hit_mask) |=> mask_reg == $past(pwdata[UIM_MSB:UIM_LSB]))
		else $error("mask write not stored");
	a_mask_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(access && pwrite && hit_mask) |=> $stable(mask_reg))
		else $error("mask changed without write");
	a_status_readonly: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_access(hit_raw || hit_mis) |=> $stable(mask_reg))
		else $error("status write changed mask");
	a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_access(hit_mask) ##0 (pwdata[UIM_MSB:UIM_LSB] == '0) |=> !uart_irq)
		else $error("line high after all masks cleared");
	a_read_raw: assert property (@(posedge pclk) disable iff (!presetn)
		s_read_setup(hit_raw) |=> prdata[UIM_MSB:UIM_LSB] == $past(raw_vec))
		else $error("raw status read wrong");
	a_read_masked: assert property (@(posedge pclk) disable iff (!presetn)
		s_read_setup(hit_mis) |=>
		prdata[UIM_MSB:UIM_LSB] == ($past(raw_vec) & $past(mask_reg)))
		else $error("masked status read wrong");

	// ----------------------------------------------------------------
	// Bus checks
	// ----------------------------------------------------------------
	a_reset_rdata: assert property (@(posedge pclk)
		!presetn |=> prdata == UIM_RDATA_IDLE)
		else $error("read data not cleared by reset");
	a_read_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		s_read_setup(!hit_any) |=> prdata == UIM_RDATA_IDLE)
		else $error("unmapped read not zero");
	a_slverr_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		(access && hit_any) |-> !pslverr)
		else $error("error on mapped offset");
	a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !hit_any) |-> pslverr)
		else $error("no error on unmapped offset");
	a_slverr_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!access |-> !pslverr)
		else $error("error outside access phase");
	a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed outside read setup");
	a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
		pready)
		else $error("wait state inserted");

endmodule : uim_mask

// [core/uim_pkg.sv]
// Package: register map, field positions and reset values of the interrupt mask block
package uim_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] UIM_MASK_OFFSET = 12'h038;
	localparam logic [11:0] UIM_RAW_OFFSET  = 12'h03C;
	localparam logic [11:0] UIM_MIS_OFFSET  = 12'h040;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int UIM_RX_BIT  = 4;
	localparam int UIM_TX_BIT  = 5;
	localparam int UIM_RT_BIT  = 6;
	localparam int UIM_FE_BIT  = 7;
	localparam int UIM_PE_BIT  = 8;
	localparam int UIM_BE_BIT  = 9;
	localparam int UIM_OE_BIT  = 10;
	localparam int UIM_LSB     = UIM_RX_BIT;
	localparam int UIM_MSB     = UIM_OE_BIT;
	localparam int UIM_NSRC    = UIM_MSB - UIM_LSB + 1;

	// ----------------------------------------------------------------
	// Reset and fixed values
	// ----------------------------------------------------------------
	localparam logic [UIM_NSRC-1:0] UIM_MASK_RESET = 7'h00;
	localparam logic [31:0]         UIM_RDATA_IDLE = 32'h0000_0000;
	localparam logic [3:0]          UIM_RSVD_LOW   = 4'h0;

endpackage : uim_pkg

// [dv/uim_far_model.sv]
// Far-side model: UART core raw interrupt sources
`timescale 1ns/10ps
module uim_far_model (
	pclk,
	raw_set,
	raw_src
);
	input  wire logic       pclk;
	input  wire logic [6:0] raw_set;
	output logic      [6:0] raw_src;

	// Raw levels change only after a clock edge
	always_ff @(posedge pclk) begin
		raw_src <= raw_set;
	end
endmodule : uim_far_model

// [dv/uim_mask_bench.sv]
// Bench: APB register and interrupt line tests of the mask block
`timescale 1ns/10ps
module uim_mask_bench;
	import uim_pkg::*;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata, q;
	logic        pready, pslverr, uart_irq, e;
	logic [6:0]  raw_set = 7'h00;
	logic [6:0]  raw;
	int          error_cnt = 0;
	int          total_checks = 0;

	always #2.5 pclk = ~pclk;

	uim_far_model uim_far_model_i (.pclk(pclk), .raw_set(raw_set), .raw_src(raw));
	uim_mask uim_mask_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .overrun_err_raw(raw[6]), .break_err_raw(raw[5]),
		.parity_err_raw(raw[4]), .framing_err_raw(raw[3]), .rx_timeout_raw(raw[2]),
		.tx_irq_raw(raw[1]), .rx_irq_raw(raw[0]), .uart_irq(uart_irq));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask : chk

	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		raw_set <= 7'h7F;
		apb(1'b0, UIM_MASK_OFFSET, 32'h0);
		chk("reset mask", 32'h0, q);
		chk("irq at reset", 32'h0, {31'h0, uart_irq});
		for (int i = 0; i < UIM_NSRC; i++) begin
			apb(1'b1, UIM_MASK_OFFSET, 32'h1 << (UIM_LSB + i));
			apb(1'b0, UIM_MASK_OFFSET, 32'h0);
			chk("mask readback", 32'h1 << (UIM_LSB + i), q);
			for (int j = 0; j < UIM_NSRC; j++) begin
				raw_set <= 7'h01 << j;
				repeat (2) @(posedge pclk);
				chk("irq line", {31'h0, i == j}, {31'h0, uart_irq});
			end
		end
		raw_set <= 7'h7F;
		apb(1'b1, UIM_MASK_OFFSET, 32'hFFFF_FFFF);
		apb(1'b0, UIM_MASK_OFFSET, 32'h0);
		chk("reserved bits", 32'h0000_07F0, q);
		apb(1'b0, UIM_MIS_OFFSET, 32'h0);
		chk("masked status", 32'h0000_07F0, q);
		apb(1'b1, UIM_MASK_OFFSET, 32'h0);
		apb(1'b0, UIM_RAW_OFFSET, 32'h0);
		chk("raw kept", 32'h0000_07F0, q);
		chk("irq blocked", 32'h0, {31'h0, uart_irq});
		apb(1'b1, UIM_RAW_OFFSET, 32'hFFFF_FFFF);
		chk("status write error", 32'h0, {31'h0, e});
		apb(1'b0, UIM_MASK_OFFSET, 32'h0);
		chk("status write ignored", 32'h0, q);
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		apb(1'b1, UIM_MASK_OFFSET, 32'hFFFF_FFFF);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, UIM_MASK_OFFSET, 32'h0);
		chk("mask after reset", 32'h0, q);
		chk("irq after reset", 32'h0, {31'h0, uart_irq});
		test_done();
	end

	initial begin
		#20000;
		error_cnt++;
		test_done();
	end
endmodule : uim_mask_bench
